// ### src/dtop_pkg.sv
// Notes on behaviour
// R1: PECI target point, RW, resets 0xFB
// R2: Remote one target point, RW, resets 0x64
// R3: Local target point, RW, resets 0x64
// R4: Remote two target point, RW, resets 0x64
// R5: Lock bit makes registers read-only
// R6: Enabled channel targets its operating point
// R7: Bit 0 is remote two cycle MSB
// R8: Cycle code sets adjustment spacing
// R9: Core-low condition sets status, raises alert
// R10: Core-low suspends hot monitor, adaptive, shutdown
// R11: Core voltage recovery re-enables suspended functions
// R12: Bit 2 captures remote one on limit
// R13: Capture clear keeps remote one programmed
// R14: Bit 3 captures local on limit
// R15: Bit 4 captures remote two on limit
// R16: Bit 5 enables remote one adaptation
// R17: Bit 6 enables local adaptation
// R18: Bit 7 enables remote two adaptation
// R19: Enable clear leaves floor, plain auto
// R20: Capture keeps the reading's 8-bit encoding
`default_nettype none
package dtop_pkg;
    localparam int unsigned DTOP_NCH = 4;             // Stored target points
    localparam logic [7:0] DTOP_ADDR_PECI = 8'h8A;    // PECI target point
    localparam logic [7:0] DTOP_ADDR_R1 = 8'h8B;      // Remote one target point
    localparam logic [7:0] DTOP_ADDR_LOC = 8'h8C;     // Local target point
    localparam logic [7:0] DTOP_ADDR_R2 = 8'h8D;      // Remote two target point
    localparam logic [7:0] DTOP_ADDR_CTL = 8'h8E;     // Adaptive floor control one
    localparam logic [7:0] DTOP_RST_PECI = 8'hFB;     // PECI reset value
    localparam logic [7:0] DTOP_RST_TEMP = 8'h64;     // 100 degrees
    localparam logic [7:0] DTOP_RST_CTL = 8'h00;      // Control reset value
    localparam int unsigned DTOP_BIT_CYC = 0;         // Remote two cycle MSB
    localparam int unsigned DTOP_BIT_VLO = 1;         // Core voltage low option
    localparam int unsigned DTOP_BIT_CAP = 2;         // First capture enable
    localparam int unsigned DTOP_BIT_ADA = 5;         // First adaptive enable
    localparam logic [1:0] DTOP_IDX_PECI = 2'h0;      // Target point index
    localparam logic [1:0] DTOP_IDX_R1 = 2'h1;
    localparam logic [1:0] DTOP_IDX_LOC = 2'h2;
    localparam logic [1:0] DTOP_IDX_R2 = 2'h3;
    typedef logic [7:0] dtop_byte_t;                  // Register byte
endpackage : dtop_pkg
`default_nettype wire

// ### src/dtop_wr_if.sv
`timescale 1ns/1ps
`default_nettype none
// Write and read path between the register decode and target store
interface dtop_wr_if;
    logic [3:0] wr_en;              // Per entry write strobe
    logic [7:0] wr_data [4];        // Per entry write data
    logic [7:0] rd_data [4];        // Per entry stored value
    modport ctl (output wr_en, output wr_data, input rd_data);
    modport mem (input wr_en, input wr_data, output rd_data);
endinterface : dtop_wr_if
`default_nettype wire

// ### src/dtop_point_store.sv
`timescale 1ns/1ps
`default_nettype none
// Four target point registers with their own reset values
module dtop_point_store
    import dtop_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    dtop_wr_if.mem port
);
    generate
        for (genvar i = 0; i < DTOP_NCH; i++) begin : g_pt
            // One entry, PECI entry resets differently
            always_ff @(posedge clk_in) begin
                if (!reset_n_in) begin
                    port.rd_data[i] <= (i == int'(DTOP_IDX_PECI)) ? DTOP_RST_PECI : DTOP_RST_TEMP; // [R1] [R2] [R3] [R4]
                end else if (clk_en_in && port.wr_en[i]) begin
                    port.rd_data[i] <= port.wr_data[i];
                end
            end
        end
    endgenerate
endmodule : dtop_point_store
`default_nettype wire

// ### src/dtop_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Target point and adaptive floor control register bank
module dtop_regs
    import dtop_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic clk_en_in,
    input wire logic wr_in,                     // Register write strobe
    input wire logic [7:0] addr_in,             // Register address
    input wire logic [7:0] wdata_in,            // Write data
    input wire logic lock_in,                   // Configuration lock bit
    input wire logic thermal_limit_pin_in,      // Limit pin, active high here
    input wire logic [7:0] remote_one_temp_in,  // Present readings
    input wire logic [7:0] local_temp_in,
    input wire logic [7:0] remote_two_temp_in,
    input wire logic standby_supply_in,         // Running from standby
    input wire logic core_below_limit_in,       // Core voltage under low limit
    output logic [7:0] rdata_out,               // Read data
    output logic [7:0] ctl_out,                 // Control register
    output logic [7:0] peci_point_out,          // Target points
    output logic [7:0] remote_one_point_out,
    output logic [7:0] local_point_out,
    output logic [7:0] remote_two_point_out,
    output logic [2:0] adaptive_active_out,     // R1, local, R2 adapt enables
    output logic remote_two_cycle_msb_out,      // Cycle code MSB
    output logic core_low_status_out,           // Status one bit 1 set
    output logic core_low_alert_out,            // Alert request
    output logic processor_hot_enable_out,      // Hot monitoring allowed
    output logic shutdown_allow_out             // Shutdown entry allowed
);
    import dtop_pkg::*;

    dtop_wr_if wr_bus ();           // Path to the target store
    dtop_byte_t ctl_q;              // Adaptive floor control one
    logic thermal_limit_pin_q;                  // Previous limit pin level
    logic thermal_limit_pin_rise;               // Limit pin assertion edge
    logic core_low;                 // Core-low condition active
    logic wr_ok;                    // Write allowed
    logic [2:0] cap_en;             // Capture enables

    dtop_point_store u_store (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .clk_en_in(clk_en_in),
        .port(wr_bus.mem)
    );

    // Writes blocked once locked
    assign wr_ok = wr_in && !lock_in; // [R5]
    assign thermal_limit_pin_rise = thermal_limit_pin_in && !thermal_limit_pin_q;
    assign cap_en = ctl_q[DTOP_BIT_CAP +: 3];
    assign core_low = ctl_q[DTOP_BIT_VLO] && standby_supply_in && core_below_limit_in; // [R9]

    // Write strobes; capture beats host write on same cycle
    always_comb begin
        for (int i = 0; i < DTOP_NCH; i++) begin
            wr_bus.wr_en[i] = 1'b0;
            wr_bus.wr_data[i] = wdata_in;
        end
        wr_bus.wr_en[DTOP_IDX_PECI] = wr_ok && (addr_in == DTOP_ADDR_PECI);
        wr_bus.wr_en[DTOP_IDX_R1] = wr_ok && (addr_in == DTOP_ADDR_R1);
        wr_bus.wr_en[DTOP_IDX_LOC] = wr_ok && (addr_in == DTOP_ADDR_LOC);
        wr_bus.wr_en[DTOP_IDX_R2] = wr_ok && (addr_in == DTOP_ADDR_R2);
        if (thermal_limit_pin_rise && cap_en[0]) begin // [R12] [R13]
            wr_bus.wr_en[DTOP_IDX_R1] = 1'b1;
            wr_bus.wr_data[DTOP_IDX_R1] = remote_one_temp_in; // [R20]
        end
        if (thermal_limit_pin_rise && cap_en[1]) begin // [R14]
            wr_bus.wr_en[DTOP_IDX_LOC] = 1'b1;
            wr_bus.wr_data[DTOP_IDX_LOC] = local_temp_in; // [R20]
        end
        if (thermal_limit_pin_rise && cap_en[2]) begin // [R15]
            wr_bus.wr_en[DTOP_IDX_R2] = 1'b1;
            wr_bus.wr_data[DTOP_IDX_R2] = remote_two_temp_in; // [R20]
        end
    end

    // Control register
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ctl_q <= DTOP_RST_CTL;
        end else if (clk_en_in && wr_ok && addr_in == DTOP_ADDR_CTL) begin
            ctl_q <= wdata_in; // [R5]
        end
    end

    // Limit pin edge history
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            thermal_limit_pin_q <= 1'b0;
        end else if (clk_en_in) begin
            thermal_limit_pin_q <= thermal_limit_pin_in;
        end
    end

    // Read mux and mirrored outputs
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= 8'h00;
            ctl_out <= DTOP_RST_CTL;
            peci_point_out <= DTOP_RST_PECI;
            remote_one_point_out <= DTOP_RST_TEMP;
            local_point_out <= DTOP_RST_TEMP;
            remote_two_point_out <= DTOP_RST_TEMP;
        end else if (clk_en_in) begin
            unique case (addr_in)
                DTOP_ADDR_PECI: rdata_out <= wr_bus.rd_data[DTOP_IDX_PECI];
                DTOP_ADDR_R1: rdata_out <= wr_bus.rd_data[DTOP_IDX_R1];
                DTOP_ADDR_LOC: rdata_out <= wr_bus.rd_data[DTOP_IDX_LOC];
                DTOP_ADDR_R2: rdata_out <= wr_bus.rd_data[DTOP_IDX_R2];
                DTOP_ADDR_CTL: rdata_out <= ctl_q;
                default: rdata_out <= 8'h00;
            endcase
            ctl_out <= ctl_q;
            peci_point_out <= wr_bus.rd_data[DTOP_IDX_PECI]; // [R6]
            remote_one_point_out <= wr_bus.rd_data[DTOP_IDX_R1];
            local_point_out <= wr_bus.rd_data[DTOP_IDX_LOC];
            remote_two_point_out <= wr_bus.rd_data[DTOP_IDX_R2];
        end
    end

    // Adaptive enables and core-low supervision
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            adaptive_active_out <= 3'h0;
            remote_two_cycle_msb_out <= 1'b0;
            core_low_status_out <= 1'b0;
            core_low_alert_out <= 1'b0;
            processor_hot_enable_out <= 1'b1;
            shutdown_allow_out <= 1'b1;
        end else if (clk_en_in) begin
            // Enabled channels adapt unless core-low suspends them
            adaptive_active_out <= core_low ? 3'h0 : ctl_q[DTOP_BIT_ADA +: 3]; // [R16] [R17] [R18] [R19] [R10] [R11]
            remote_two_cycle_msb_out <= ctl_q[DTOP_BIT_CYC]; // [R7] [R8]
            core_low_status_out <= core_low; // [R9]
            core_low_alert_out <= core_low; // [R9]
            processor_hot_enable_out <= !core_low; // [R10] [R11]
            shutdown_allow_out <= !core_low; // [R10] [R11]
        end
    end

    // Lock leaves the PECI point alone
    a_lock_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R5]
        (clk_en_in && lock_in && !thermal_limit_pin_rise) |=> $stable(wr_bus.rd_data[DTOP_IDX_PECI]))
        else $error("locked point changed");

    // Lock leaves the control register alone
    a_ctl_lock: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R5]
        lock_in |=> $stable(ctl_q))
        else $error("locked control changed");

    // Limit pin edge loads remote one reading
    a_cap_remote1: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R12]
        (clk_en_in && thermal_limit_pin_rise && cap_en[0]) |=> wr_bus.rd_data[DTOP_IDX_R1] == $past(remote_one_temp_in))
        else $error("remote one capture missed");

    // Limit pin edge loads local reading
    a_cap_local: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R14]
        (clk_en_in && thermal_limit_pin_rise && cap_en[1]) |=> wr_bus.rd_data[DTOP_IDX_LOC] == $past(local_temp_in))
        else $error("local capture missed");

    // Limit pin edge loads remote two reading
    a_cap_remote2: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R15]
        (clk_en_in && thermal_limit_pin_rise && cap_en[2]) |=> wr_bus.rd_data[DTOP_IDX_R2] == $past(remote_two_temp_in))
        else $error("remote two capture missed");

    // Capture off keeps remote one programmed
    a_no_capture: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R13]
        (clk_en_in && !cap_en[0] && !wr_bus.wr_en[DTOP_IDX_R1]) |=> $stable(wr_bus.rd_data[DTOP_IDX_R1]))
        else $error("remote one changed uncaptured");

    // Core-low suspends adaptation, hot monitor, shutdown
    a_core_suspend: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R10]
        (clk_en_in && core_low) |=> (adaptive_active_out == 3'h0 && !processor_hot_enable_out && !shutdown_allow_out))
        else $error("core low not suspending");

    // Status bit follows the core-low level
    a_core_status: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R9]
        clk_en_in |=> core_low_status_out == $past(core_low))
        else $error("status bit mismatch");

    // Adaptive enables follow control while supply is fine
    a_adapt_en: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R16] [R17] [R18]
        (clk_en_in && !core_low) |=> adaptive_active_out == $past(ctl_q[DTOP_BIT_ADA +: 3]))
        else $error("adaptive enable mismatch");

    // Reset loads the PECI default
    a_reset_peci: assert property (@(posedge clk_in) // [R1]
        !reset_n_in |=> (peci_point_out == DTOP_RST_PECI && wr_bus.rd_data[DTOP_IDX_PECI] == DTOP_RST_PECI))
        else $error("PECI reset value wrong");

    // Reset loads the temperature defaults
    a_reset_points: assert property (@(posedge clk_in) // [R2] [R3] [R4]
        !reset_n_in |=> (remote_one_point_out == DTOP_RST_TEMP && local_point_out == DTOP_RST_TEMP
            && remote_two_point_out == DTOP_RST_TEMP))
        else $error("point reset value wrong");

    // Reset clears control and adaptation
    a_reset_ctl: assert property (@(posedge clk_in) // [R7] [R19]
        !reset_n_in |=> (ctl_q == DTOP_RST_CTL && ctl_out == DTOP_RST_CTL && adaptive_active_out == 3'h0))
        else $error("control reset value wrong");

    // PECI target point mirrored out
    a_mirror_peci: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R6]
        clk_en_in |=> peci_point_out == $past(wr_bus.rd_data[DTOP_IDX_PECI]))
        else $error("PECI point output stale");

    // Remote one target point mirrored out
    a_mirror_remote1: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R6]
        clk_en_in |=> remote_one_point_out == $past(wr_bus.rd_data[DTOP_IDX_R1]))
        else $error("remote one point output stale");

    // Local target point mirrored out
    a_mirror_local: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R6]
        clk_en_in |=> local_point_out == $past(wr_bus.rd_data[DTOP_IDX_LOC]))
        else $error("local point output stale");

    // Remote two target point mirrored out
    a_mirror_remote2: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R6]
        clk_en_in |=> remote_two_point_out == $past(wr_bus.rd_data[DTOP_IDX_R2]))
        else $error("remote two point output stale");

    // Host write lands in the PECI point
    a_write_peci: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R1]
        (clk_en_in && wr_ok && addr_in == DTOP_ADDR_PECI)
            |=> wr_bus.rd_data[DTOP_IDX_PECI] == $past(wdata_in))
        else $error("PECI write lost");

    // Host write lands in remote one unless captured
    a_write_remote1: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R2]
        (clk_en_in && wr_ok && addr_in == DTOP_ADDR_R1 && !(thermal_limit_pin_rise && cap_en[0]))
            |=> wr_bus.rd_data[DTOP_IDX_R1] == $past(wdata_in))
        else $error("remote one write lost");

    // Host write lands in local unless captured
    a_write_local: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R3]
        (clk_en_in && wr_ok && addr_in == DTOP_ADDR_LOC && !(thermal_limit_pin_rise && cap_en[1]))
            |=> wr_bus.rd_data[DTOP_IDX_LOC] == $past(wdata_in))
        else $error("local write lost");

    // Host write lands in remote two unless captured
    a_write_remote2: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R4]
        (clk_en_in && wr_ok && addr_in == DTOP_ADDR_R2 && !(thermal_limit_pin_rise && cap_en[2]))
            |=> wr_bus.rd_data[DTOP_IDX_R2] == $past(wdata_in))
        else $error("remote two write lost");

    // Host write lands in the control register
    a_ctl_write: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R7]
        (clk_en_in && wr_ok && addr_in == DTOP_ADDR_CTL) |=> ctl_q == $past(wdata_in))
        else $error("control write lost");

    // Read returns the stored remote one point
    a_read_remote1: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R2]
        (clk_en_in && addr_in == DTOP_ADDR_R1) |=> rdata_out == $past(wr_bus.rd_data[DTOP_IDX_R1]))
        else $error("remote one read wrong");

    // Lock keeps the channel points unless captured
    a_lock_points: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R5]
        (lock_in && !thermal_limit_pin_rise) |=> ($stable(wr_bus.rd_data[DTOP_IDX_R1]) && $stable(wr_bus.rd_data[DTOP_IDX_LOC])
            && $stable(wr_bus.rd_data[DTOP_IDX_R2])))
        else $error("locked channel point changed");

    // Capture off keeps local programmed
    a_nocap_local: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R14]
        (clk_en_in && !cap_en[1] && !wr_bus.wr_en[DTOP_IDX_LOC]) |=> $stable(wr_bus.rd_data[DTOP_IDX_LOC]))
        else $error("local changed uncaptured");

    // Capture off keeps remote two programmed
    a_nocap_remote2: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R15]
        (clk_en_in && !cap_en[2] && !wr_bus.wr_en[DTOP_IDX_R2]) |=> $stable(wr_bus.rd_data[DTOP_IDX_R2]))
        else $error("remote two changed uncaptured");

    // Cycle code MSB follows control bit 0
    a_msb_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R7] [R8]
        clk_en_in |=> remote_two_cycle_msb_out == $past(ctl_q[DTOP_BIT_CYC]))
        else $error("cycle code MSB wrong");

    // Alert request follows the core-low level
    a_alert_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R9]
        clk_en_in |=> core_low_alert_out == $past(core_low))
        else $error("alert request wrong");

    // Hot monitor allowed exactly when core-low is not active
    a_hot_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R10] [R11]
        clk_en_in |=> processor_hot_enable_out == !$past(core_low))
        else $error("hot monitor enable wrong");

    // Shutdown allowed exactly when core-low is not active
    a_shutdown_follow: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R10] [R11]
        clk_en_in |=> shutdown_allow_out == !$past(core_low))
        else $error("shutdown enable wrong");

    // Option bit clear never flags core-low
    a_option_off: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R9]
        (clk_en_in && !ctl_q[DTOP_BIT_VLO]) |=> !core_low_status_out)
        else $error("status set with option off");

    // Remote one stays plain when its enable is clear
    a_remote1_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R16] [R19]
        (clk_en_in && !ctl_q[DTOP_BIT_ADA]) |=> !adaptive_active_out[0])
        else $error("remote one adapting while off");

    // Local stays plain when its enable is clear
    a_local_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R17] [R19]
        (clk_en_in && !ctl_q[DTOP_BIT_ADA + 1]) |=> !adaptive_active_out[1])
        else $error("local adapting while off");

    // Remote two stays plain when its enable is clear
    a_remote2_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in) // [R18] [R19]
        (clk_en_in && !ctl_q[DTOP_BIT_ADA + 2]) |=> !adaptive_active_out[2])
        else $error("remote two adapting while off");

    // Main scenarios reached
    c_capture: cover property (@(posedge clk_in) thermal_limit_pin_rise && cap_en[0]);
    c_core_low: cover property (@(posedge clk_in) core_low ##1 !core_low);
    c_locked_write: cover property (@(posedge clk_in) wr_in && lock_in);
    c_local_capture: cover property (@(posedge clk_in) clk_en_in && thermal_limit_pin_rise && cap_en[1]);
    c_mid_reset: cover property (@(posedge clk_in) !reset_n_in ##1 reset_n_in);
endmodule : dtop_regs
`default_nettype wire

// ### src/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### dv/dtop_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Management host: register cycles launched on the falling edge
module dtop_host_model (
    input wire logic clk_in,
    output logic wr_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic rd_pend_out
);
    // Idle bus at time zero
    initial begin
        wr_out = 1'b0;
        addr_out = 8'h00;
        wdata_out = 8'h00;
        rd_pend_out = 1'b0;
    end
    // One write, data scrambled once released
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_out = 1'b1;
        addr_out = a;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
    endtask
    // Address held one cycle, result flagged
    task automatic read(input logic [7:0] a);
        @(negedge clk_in);
        addr_out = a;
        rd_pend_out = 1'b1;
        @(negedge clk_in);
        rd_pend_out = 1'b0;
    endtask
endmodule // dtop_host_model
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the target point bank
module testbench;
    import dtop_pkg::*;
    logic clk_in, reset_n_in, clk_en_in, lock_in, pin, standby, below, chk_d;
    logic wr, pend;
    logic [7:0] addr, wdata, t1, tl, t2, rdata, ctl, pp, p1, pl, p2;
    logic [2:0] ada;
    logic msb, st, al, hot, sd;
    dtop_byte_t v [5];
    dtop_byte_t exp_q [$];
    int bad_count, compares;
    dtop_host_model dtop_host_model_inst (.clk_in(clk_in), .wr_out(wr), .addr_out(addr), .wdata_out(wdata),
        .rd_pend_out(pend));
    dtop_regs dtop_regs_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in), .wr_in(wr),
        .addr_in(addr), .wdata_in(wdata), .lock_in(lock_in), .thermal_limit_pin_in(pin),
        .remote_one_temp_in(t1), .local_temp_in(tl), .remote_two_temp_in(t2), .standby_supply_in(standby),
        .core_below_limit_in(below), .rdata_out(rdata), .ctl_out(ctl), .peci_point_out(pp),
        .remote_one_point_out(p1), .local_point_out(pl), .remote_two_point_out(p2),
        .adaptive_active_out(ada), .remote_two_cycle_msb_out(msb), .core_low_status_out(st),
        .core_low_alert_out(al), .processor_hot_enable_out(hot), .shutdown_allow_out(sd));
    // Clock at 25 MHz
    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end
    // Counts, verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One comparison
    task automatic check(input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Note the expected read, then issue it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        dtop_host_model_inst.read(a);
    endtask
    // Core-low outputs: status, alert, hot enable, shutdown, adaptive
    task automatic core(input logic lo, input logic [2:0] ea);
        repeat (2) @(negedge clk_in);
        check({4'h0, lo, lo, ~lo, ~lo}, {4'h0, st, al, hot, sd});
        check({5'h00, ea}, {5'h00, ada});
    endtask
    // Read checker fed by the rising edge after each read, compared on the next falling edge
    always @(posedge clk_in) chk_d <= pend;
    always @(negedge clk_in) begin
        if (chk_d === 1'b1) check(exp_q.pop_front(), rdata);
    end
    // Hang guard
    initial begin
        repeat (4000) @(posedge clk_in);
        bad_count++;
        results();
    end
    // Main sequence
    initial begin
        {reset_n_in, lock_in, pin, standby, below} = 5'h00;
        clk_en_in = 1'b1;
        {t1, tl, t2} = 24'h000000;
        void'($urandom(48));
        repeat (2) @(negedge clk_in);
        reset_n_in = 1'b1;
        rd(DTOP_ADDR_PECI, 8'hFB);
        for (int i = 1; i < 4; i++) rd(DTOP_ADDR_PECI + 8'(i), 8'h64);
        rd(DTOP_ADDR_CTL, 8'h00);
        rd(8'h10, 8'h00);
        check(8'hFB, pp);
        check(8'h64, p1);
        check(8'h64, pl);
        check(8'h64, p2);
        for (int i = 0; i < 5; i++) begin
            v[i] = 8'($urandom);
            dtop_host_model_inst.write(DTOP_ADDR_PECI + 8'(i), v[i]);
        end
        for (int i = 0; i < 5; i++) rd(DTOP_ADDR_PECI + 8'(i), v[i]);
        check(v[4], ctl);
        check({7'h00, v[4][0]}, {7'h00, msb});
        check({5'h00, v[4][7:5]}, {5'h00, ada});
        lock_in = 1'b1;
        dtop_host_model_inst.write(DTOP_ADDR_R1, ~v[1]);
        rd(DTOP_ADDR_R1, v[1]);
        lock_in = 1'b0;
        clk_en_in = 1'b0;
        dtop_host_model_inst.write(DTOP_ADDR_R2, ~v[3]);
        clk_en_in = 1'b1;
        rd(DTOP_ADDR_R2, v[3]);
        dtop_host_model_inst.write(DTOP_ADDR_CTL, 8'h1C);
        {t1, tl, t2} = 24'($urandom);
        pin = 1'b1;
        @(negedge clk_in);
        pin = 1'b0;
        rd(DTOP_ADDR_R1, t1);
        rd(DTOP_ADDR_LOC, tl);
        rd(DTOP_ADDR_R2, t2);
        rd(DTOP_ADDR_PECI, v[0]);
        v[1] = t1;
        v[2] = tl;
        v[3] = t2;
        check(v[0], pp);
        check(v[1], p1);
        check(v[2], pl);
        check(v[3], p2);
        dtop_host_model_inst.write(DTOP_ADDR_CTL, 8'h00);
        {t1, tl, t2} = ~{t1, tl, t2};
        pin = 1'b1;
        @(negedge clk_in);
        pin = 1'b0;
        for (int i = 1; i < 4; i++) rd(DTOP_ADDR_PECI + 8'(i), v[i]);
        dtop_host_model_inst.write(DTOP_ADDR_CTL, 8'hE2);
        standby = 1'b1;
        below = 1'b1;
        core(1'b1, 3'h0);
        below = 1'b0;
        core(1'b0, 3'h7);
        dtop_host_model_inst.write(DTOP_ADDR_CTL, 8'hE0);
        below = 1'b1;
        core(1'b0, 3'h7);
        // Second reset in mid-run restores defaults
        reset_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        reset_n_in = 1'b1;
        rd(DTOP_ADDR_R1, 8'h64);
        rd(DTOP_ADDR_CTL, 8'h00);
        check(8'hFB, pp);
        core(1'b0, 3'h0);
        repeat (3) @(negedge clk_in);
        check(8'h00, 8'(exp_q.size()));
        results();
    end
endmodule // testbench
`default_nettype wire
